// >>> logic/tkgp_pkg.sv
// tkgp_pkg: register map, reset values and carrier types of the touchkey gpio port
// assumes an i2c slave front end elsewhere presents byte-wide register accesses
package tkgp_pkg;

    localparam int unsigned NUM_PINS = 3;
    localparam int unsigned ADDR_W = 8;

    // register offsets (byte addresses on the i2c register space)
    localparam logic [7:0] OFS_IRQ_EN_LO = 8'h0b;
    localparam logic [7:0] OFS_IRQ_EN_HI = 8'h0c;
    localparam logic [7:0] OFS_IRQ_FLAG_LO = 8'h0d;
    localparam logic [7:0] OFS_IRQ_FLAG_HI = 8'h0e;
    localparam logic [7:0] OFS_MON_LO = 8'h10;
    localparam logic [7:0] OFS_MON_HI = 8'h11;
    localparam logic [7:0] OFS_OUT_LO = 8'h12;
    localparam logic [7:0] OFS_OUT_HI = 8'h13;
    localparam logic [7:0] OFS_DIR_LO = 8'h14;
    localparam logic [7:0] OFS_DIR_HI = 8'h15;
    localparam logic [7:0] OFS_FUNC_LO = 8'h16;
    localparam logic [7:0] OFS_FUNC_HI = 8'h17;

    // reset values
    localparam logic [2:0] RST_IRQ_EN = 3'h0;
    localparam logic [2:0] RST_IRQ_FLAG = 3'h0;
    localparam logic [2:0] RST_OUT = 3'h0;
    localparam logic [2:0] RST_DIR = 3'h0;
    localparam logic [2:0] RST_FUNC = 3'h0;
    localparam logic [2:0] RST_LEVEL = 3'h0;
    localparam logic [7:0] RST_RDATA = 8'h00;

    // global aggregate bit position in the global irq flag byte
    localparam int unsigned GLOBAL_GPIO_BIT = 7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tkgp_req_t;

    typedef struct packed {
        logic [2:0] in;
        logic [2:0] out;
        logic [2:0] oe;
    } tkgp_pins_t;

endpackage : tkgp_pkg

// >>> logic/tkgp_port.sv
// tkgp_port: three-pin gpio port shared with touch channels, with per-pin irq flags
// assumes an i2c slave supplies one-cycle byte strobes, auto-increment done by it
//
// How it works
// - enable bits 2:0 map one-to-one onto pins 2:0
// - enable one lets a pin event reach the host irq; zero blocks it
// - enable bits 7:3 are reserved and read zero
// - mask gates each pin's flag individually toward the host
// - monitor reads present pin level, writes ignored
// - output level bit one drives pin high, zero low
// - direction zero is input, one output, reset all inputs
// - function one is gpio, zero hands pin to touch channel
// - global gpio bit 7 set when enabled pins owned by the gpio function see a transition
`timescale 1ns/1ps
`default_nettype none

module tkgp_port (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register access from the i2c slave
    input wire tkgp_pkg::tkgp_req_t req,
    output logic [7:0] rdata,
    // pads
    input wire logic [2:0] pin_in,
    output logic [2:0] pin_out,
    output logic [2:0] pin_oe,
    // touch channel ownership
    output logic [2:0] touch_sel,
    // toward the global interrupt controller
    output logic gpio_irq_pending,
    output logic [7:0] global_gpio_bit
);

    ////////////////////////////////////////////////////////////////////////
    // configuration registers and their next values
    logic [2:0] irq_en_reg;
    logic [2:0] irq_en_next;
    logic [2:0] out_reg;
    logic [2:0] out_next;
    logic [2:0] dir_reg;
    logic [2:0] dir_next;
    logic [2:0] func_reg;
    logic [2:0] func_next;

    // pin sampling, sticky flags and read data
    logic [2:0] level_reg;
    logic [2:0] level_prev_reg;
    logic [2:0] irq_flag_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // write decode; only the low byte of each pair holds state
    wire logic wr_en_lo = req.wr && (req.addr == tkgp_pkg::OFS_IRQ_EN_LO);
    wire logic wr_flag_lo = req.wr && (req.addr == tkgp_pkg::OFS_IRQ_FLAG_LO);
    wire logic wr_out_lo = req.wr && (req.addr == tkgp_pkg::OFS_OUT_LO);
    wire logic wr_dir_lo = req.wr && (req.addr == tkgp_pkg::OFS_DIR_LO);
    wire logic wr_func_lo = req.wr && (req.addr == tkgp_pkg::OFS_FUNC_LO);
    // monitor and high-byte writes decode to nothing and are dropped
    // bits 7:3 of every write are reserved and never stored
    wire logic [2:0] wr_bits = req.wdata[2:0];

    ////////////////////////////////////////////////////////////////////////
    // next values of the configuration registers
    assign irq_en_next = wr_en_lo ? wr_bits : irq_en_reg;
    assign out_next = wr_out_lo ? wr_bits : out_reg;
    assign dir_next = wr_dir_lo ? wr_bits : dir_reg;
    assign func_next = wr_func_lo ? wr_bits : func_reg;

    ////////////////////////////////////////////////////////////////////////
    // per-pin edge detect and sticky flag
    wire logic [2:0] clr_mask = wr_flag_lo ? wr_bits : 3'h0;
    wire logic [2:0] pin_event;
    wire logic [2:0] irq_flag_next;
    wire logic [2:0] irq_gated;

    genvar p;
    generate
        for (p = 0; p < tkgp_pkg::NUM_PINS; p++) begin : g_pin
            // edges only count while the pin is owned by the gpio function
            wire logic level_edge = level_reg[p] ^ level_prev_reg[p];
            assign pin_event[p] = level_edge & func_reg[p];
            // set wins over a clear in the same cycle, so no event is lost
            assign irq_flag_next[p] = (irq_flag_reg[p] & ~clr_mask[p])
                | pin_event[p];
            // the enable gates only the forward path, never the flag itself
            assign irq_gated[p] = irq_flag_reg[p] & irq_en_reg[p];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read mux; high bytes are reserved and read zero
    always_comb begin
        rdata_next = 8'h00;
        unique case (req.addr)
            tkgp_pkg::OFS_IRQ_EN_LO: rdata_next = {5'h00, irq_en_reg};
            tkgp_pkg::OFS_IRQ_EN_HI: rdata_next = 8'h00;
            tkgp_pkg::OFS_IRQ_FLAG_LO: rdata_next = {5'h00, irq_flag_reg};
            tkgp_pkg::OFS_IRQ_FLAG_HI: rdata_next = 8'h00;
            tkgp_pkg::OFS_MON_LO: rdata_next = {5'h00, level_reg};
            tkgp_pkg::OFS_MON_HI: rdata_next = 8'h00;
            tkgp_pkg::OFS_OUT_LO: rdata_next = {5'h00, out_reg};
            tkgp_pkg::OFS_OUT_HI: rdata_next = 8'h00;
            tkgp_pkg::OFS_DIR_LO: rdata_next = {5'h00, dir_reg};
            tkgp_pkg::OFS_DIR_HI: rdata_next = 8'h00;
            tkgp_pkg::OFS_FUNC_LO: rdata_next = {5'h00, func_reg};
            tkgp_pkg::OFS_FUNC_HI: rdata_next = 8'h00;
            // unmapped addresses read zero rather than stale data
            default: rdata_next = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt enable mask
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_en_reg <= tkgp_pkg::RST_IRQ_EN;
        end else begin
            irq_en_reg <= irq_en_next;
        end
    end

    // output level
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_reg <= tkgp_pkg::RST_OUT;
        end else begin
            out_reg <= out_next;
        end
    end

    // direction; every pin comes out of reset as an input
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dir_reg <= tkgp_pkg::RST_DIR;
        end else begin
            dir_reg <= dir_next;
        end
    end

    // function select; reset hands every pin to the touch channel
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            func_reg <= tkgp_pkg::RST_FUNC;
        end else begin
            func_reg <= func_next;
        end
    end

    // sticky flags
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_flag_reg <= tkgp_pkg::RST_IRQ_FLAG;
        end else begin
            irq_flag_reg <= irq_flag_next;
        end
    end

    // pad level; pins are taken as synchronous, one stage only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            level_reg <= tkgp_pkg::RST_LEVEL;
        end else begin
            level_reg <= pin_in;
        end
    end

    // previous level for the edge detector
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            level_prev_reg <= tkgp_pkg::RST_LEVEL;
        end else begin
            level_prev_reg <= level_reg;
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_reg <= tkgp_pkg::RST_RDATA;
        end else if (req.rd) begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad, ownership and interrupt outputs
    assign rdata = rdata_reg;
    assign pin_out = out_reg & func_reg;
    // a touch-owned pin is never driven, whatever its direction bit says
    assign pin_oe = dir_reg & func_reg;
    assign touch_sel = ~func_reg;
    assign gpio_irq_pending = |irq_gated;
    // unused pins left as inputs draw more current; left to host software
    assign global_gpio_bit = {|irq_gated, 7'h00};

endmodule : tkgp_port

`default_nettype wire

// >>> test/tkgp_port_checker.sv
// tkgp_port_checker: port assertions, bound into tkgp_port
`timescale 1ns/1ps
`default_nettype none
module tkgp_port_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register access
    input wire tkgp_pkg::tkgp_req_t req,
    input wire logic [7:0] rdata,
    // pads and ownership
    input wire logic [2:0] pin_in,
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe,
    input wire logic [2:0] touch_sel,
    // interrupt outputs
    input wire logic gpio_irq_pending,
    input wire logic [7:0] global_gpio_bit
);
    wire [7:0] a = req.addr;
    wire [2:0] wd = req.wdata[2:0];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_RST: assert property (disable iff (1'b0) sys_rst |=> pin_oe == 3'h0)
        else $error("reset");
    AST_GLB: assert property (global_gpio_bit == {gpio_irq_pending, 7'h0})
        else $error("glb");
    AST_FN: assert property (req.wr && a == 8'h16 |=> touch_sel == ~$past(wd))
        else $error("func");
    AST_DIR: assert property (req.wr && a == 8'h14 |=> pin_oe == ($past(wd) & ~touch_sel))
        else $error("dir");
    AST_OUT: assert property (req.wr && a == 8'h12 |=> pin_out == ($past(wd) & ~touch_sel))
        else $error("out");
    AST_EN: assert property (req.wr && a == 8'h0b && wd == 3'h0 |=> !gpio_irq_pending)
        else $error("en");
    AST_RSV: assert property (req.rd && a == 8'h0b |=> rdata[7:3] == 5'h0)
        else $error("rsv");
    AST_MON: assert property (req.rd && a == 8'h10 && $stable(pin_in) |=> rdata == {5'h0, $past(pin_in)})
        else $error("mon");
endmodule : tkgp_port_checker
bind tkgp_port tkgp_port_checker tkgp_port_checker_i (.*);
`default_nettype wire

// >>> test/tkgp_host.sv
// tkgp_host: host model issuing byte register strobes, one at a time
`timescale 1ns/1ps
`default_nettype none
module tkgp_host (
    input wire logic clk_sys,
    output var tkgp_pkg::tkgp_req_t req,
    input wire logic [7:0] rdata
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys) req <= '{1'b1, 1'b0, a, v};
        @(posedge clk_sys) req <= '0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) req <= '0;
        #1 d = rdata;
    endtask : rd
endmodule : tkgp_host
`default_nettype wire

// >>> test/tkgp_port_tb_top.sv
// tkgp_port_tb_top: host model on the bus, bench plays the pads
`timescale 1ns/1ps
`default_nettype none
module tkgp_port_tb_top;
    logic clk_sys = 0, sys_rst = 1, irq;
    logic [2:0] ext = 3'h0, pin_out, pin_oe, touch_sel;
    logic [7:0] rdata, glb, d;
    int num_errors = 0, comparisons = 0;
    tkgp_pkg::tkgp_req_t req;
    // pad level: the port's drive wins where pin_oe is set, ext elsewhere
    wire [2:0] pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
    always #2 clk_sys = ~clk_sys;
    tkgp_host tkgp_host_i (.clk_sys(clk_sys), .req(req), .rdata(rdata));
    tkgp_port tkgp_port_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .req(req), .rdata(rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .touch_sel(touch_sel),
        .gpio_irq_pending(irq), .global_gpio_bit(glb));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(string n, logic [7:0] a, logic [7:0] e);
        tkgp_host_i.rd(a, d);
        chk(n, e, d);
    endtask : rchk
    task automatic w(logic [7:0] a, logic [7:0] v);
        tkgp_host_i.wr(a, v);
    endtask : w
    task automatic t_pins;
        w(8'h16, 8'hff);
        w(8'h14, 8'h07);
        w(8'h12, 8'h05);
        chk("pads", 8'h05, {2'h0, touch_sel, pin_oe[0], pin_out[1:0]});
        chk("out", 8'h05, {5'h0, pin_out});
        rchk("outrd", 8'h12, 8'h05);
        rchk("funcrd", 8'h16, 8'h07);
        rchk("mon", 8'h10, 8'h05);
        w(8'h10, 8'h00);
        rchk("mon", 8'h10, 8'h05);
        rchk("hi", 8'h15, 8'h00);
        w(8'h14, 8'h00);
        $display("t_pins end");
    endtask : t_pins
    task automatic t_irq;
        w(8'h0b, 8'hff);
        rchk("en", 8'h0b, 8'h07);
        w(8'h0d, 8'hff);
        w(8'h0b, 8'h01);
        @(posedge clk_sys) ext <= 3'h2;
        repeat (3) @(posedge clk_sys);
        rchk("flag", 8'h0d, 8'h02);
        chk("irq", 8'h00, {irq, glb[6:0]});
        w(8'h0b, 8'h02);
        chk("glb", 8'h80, glb);
        w(8'h0d, 8'h05);
        rchk("keep", 8'h0d, 8'h02);
        w(8'h0d, 8'h02);
        chk("clr", 8'h00, glb);
        @(posedge clk_sys) ext <= 3'h0;
        repeat (3) @(posedge clk_sys);
        chk("fall", 8'h80, glb);
        w(8'h0b, 8'h00);
        chk("mask", 8'h00, glb);
        w(8'h14, 8'h07);
        $display("t_irq end");
    endtask : t_irq
    task automatic t_reset_chk;
        rchk("dir", 8'h14, 8'h00);
        rchk("flagrst", 8'h0d, 8'h00);
        chk("touch", 8'h07, {5'h0, touch_sel});
        chk("glbrst", 8'h00, glb);
        $display("t_reset_chk end");
    endtask : t_reset_chk
    task automatic t_mid_reset;
        @(posedge clk_sys) sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset_chk;
        $display("t_mid_reset end");
    endtask : t_mid_reset
    task automatic end_of_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset_chk;
        t_pins;
        t_irq;
        t_mid_reset;
        end_of_test;
    end
endmodule : tkgp_port_tb_top
`default_nettype wire
